// file: src/refresh_pkg.sv
// constants shared by the refresh mode-control block and its helpers
// assumes a 32-bit avalon-mm slave with a byte address of four bits
package refresh_pkg;
   // register byte offsets, one aligned word each
   localparam logic [3:0] OFS_MODE = 4'h0;
   localparam logic [3:0] OFS_TIMER_CTRL = 4'h4;
   localparam logic [3:0] OFS_COUNT = 4'h8;
   localparam logic [3:0] OFS_CONSTANT = 4'hc;
   // mode register field positions
   localparam int BIT_SELF = 7;
   localparam int BIT_PSRAM = 6;
   localparam int BIT_DRAM = 5;
   localparam int BIT_STROBE = 4;
   localparam int BIT_COLUMN = 3;
   localparam int BIT_PIN = 2;
   localparam int BIT_CYCLE = 0;
   // timer control field positions
   localparam int BIT_CMF = 7;
   localparam int BIT_CMIE = 6;
   localparam int BIT_CKS_HI = 5;
   localparam int BIT_CKS_LO = 3;
   // reset values and masks
   localparam logic [7:0] MODE_RESET = 8'h02;
   localparam logic [7:0] MODE_FIXED_ONE = 8'h02;
   localparam logic [7:0] MODE_LOCK_MASK = 8'h1d;
   localparam logic [2:0] CKS_RESET = 3'h0;
   localparam logic [2:0] TIMER_LOW_ONES = 3'h7;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] CONSTANT_RESET = 8'hff;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam logic [23:0] READ_UPPER = 24'h000000;
   // a refresh cycle on area 3 lasts this many states
   localparam logic [1:0] REFRESH_STATES = 2'h3;
   // run phase of the refresh cycle sequencer
   typedef enum logic {CYCLE_IDLE, CYCLE_RUN} cycle_phase_t;
   // standby handling of the attached memory
   typedef enum logic [1:0] {MEM_NORMAL, MEM_SELF_REFRESH, MEM_STANDBY_IDLE} mem_phase_t;
endpackage : refresh_pkg

// file: src/refresh_cycle_seq.sv
// refresh cycle sequencer: one start pulse gives a fixed-length cycle
// assumes start is only raised while the sequencer is idle
`timescale 1ns/1ps
module refresh_cycle_seq (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   output logic busy_out
);
   // whole state in one struct
   typedef struct packed {
      refresh_pkg::cycle_phase_t phase; // idle or running
      logic [1:0] count; // states spent in the cycle
   } seq_state_t;

   seq_state_t cur; // registered state
   seq_state_t next_cur; // next state

   // next-state logic
   always_comb begin
      next_cur = cur;
      case (cur.phase)
         refresh_pkg::CYCLE_IDLE: begin
            if (start_in) begin
               next_cur.phase = refresh_pkg::CYCLE_RUN;
               next_cur.count = 2'h0;
            end
         end
         refresh_pkg::CYCLE_RUN: begin
            // last state ends the cycle; one idle state follows
            if (cur.count == refresh_pkg::REFRESH_STATES - 2'h1) begin
               next_cur.phase = refresh_pkg::CYCLE_IDLE;
            end
            next_cur.count = cur.count + 2'h1;
         end
         default: begin
            next_cur.phase = refresh_pkg::CYCLE_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cur <= '{phase: refresh_pkg::CYCLE_IDLE, count: 2'h0};
      end else begin
         cur <= next_cur;
      end
   end

   assign busy_out = (cur.phase == refresh_pkg::CYCLE_RUN);
endmodule : refresh_cycle_seq

// file: src/self_refresh_ctl.sv
// standby tracker: chooses self-refresh or plain idle on standby entry
// assumes standby_in is a clean level from the power controller
`timescale 1ns/1ps
module self_refresh_ctl (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic standby_in,
   input wire logic allowed_in,
   output logic self_refresh_out
);
   // whole state in one struct
   typedef struct packed {
      refresh_pkg::mem_phase_t phase; // memory standby phase
   } sr_state_t;

   sr_state_t cur; // registered state
   sr_state_t next_cur; // next state

   // entry decides once; later setting changes wait for the next entry
   always_comb begin
      next_cur = cur;
      case (cur.phase)
         refresh_pkg::MEM_NORMAL: begin
            if (standby_in && allowed_in) begin
               next_cur.phase = refresh_pkg::MEM_SELF_REFRESH;
            end else if (standby_in) begin
               next_cur.phase = refresh_pkg::MEM_STANDBY_IDLE;
            end
         end
         refresh_pkg::MEM_SELF_REFRESH, refresh_pkg::MEM_STANDBY_IDLE: begin
            // leaving standby resumes normal access
            if (!standby_in) begin
               next_cur.phase = refresh_pkg::MEM_NORMAL;
            end
         end
         default: begin
            next_cur.phase = refresh_pkg::MEM_NORMAL;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cur <= '{phase: refresh_pkg::MEM_NORMAL};
      end else begin
         cur <= next_cur;
      end
   end

   assign self_refresh_out = (cur.phase == refresh_pkg::MEM_SELF_REFRESH);
endmodule : self_refresh_ctl

// file: src/refresh_mode_control.sv
// refresh mode-control register with its avalon-mm slave and pin mux
// assumes timer counting and dram strobe waveforms live outside
// Operation
// - 8-bit mode register resets to 0x02
// - psram only plus select bit: self-refresh
// - dram only plus select bit: self-refresh
// - leaving standby resumes normal memory access
// - attach bits pick timer, dram or psram
// - attached area 3 cycles last three states
// - area3 select low forbids wait states
// - attached locks config bits and timer registers
// - strobe bit picks write or column strobes
// - column bit picks 8 or 9 columns
// - pin enable drives strobe, else port
// - bit 1 always reads as one
// - refresh cycles need attachment and enable
// - strobe pin low during each refresh
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
module refresh_mode_control (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic hw_standby_in,
   input wire logic sw_standby_in,
   input wire logic [3:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [31:0] writedata_in,
   input wire logic [3:0] byteenable_in,
   output logic [31:0] readdata_out,
   output logic waitrequest_out,
   input wire logic compare_match_in,
   input wire logic refresh_request_in,
   input wire logic area3_state_select_in,
   input wire logic refresh_strobe_pin_in,
   input wire logic port_data_in,
   input wire logic port_oe_in,
   output logic refresh_strobe_pin_out,
   output logic refresh_strobe_pin_oe_out,
   output logic port_read_out,
   output logic dram_attach_out,
   output logic psram_attach_out,
   output logic two_cas_mode_out,
   output logic nine_bit_column_out,
   output logic area3_three_state_out,
   output logic area3_wait_enable_out,
   output logic refresh_cycle_out,
   output logic self_refresh_out,
   output logic compare_match_flag_out,
   output logic compare_interrupt_enable_out,
   output logic [2:0] clock_select_out,
   output logic [7:0] refresh_timer_count_out,
   output logic [7:0] refresh_time_constant_out
);
   // all block state in one struct
   typedef struct packed {
      logic [7:0] mode; // refresh_mode_control contents
      logic compare_match_flag; // compare_match_flag
      logic cmf_seen; // flag was read as one
      logic cmie; // compare interrupt enable
      logic [2:0] cks; // timer clock select
      logic [7:0] count; // refresh_timer_count
      logic [7:0] constant; // refresh_time_constant
      logic ack; // bus answer cycle
      logic [31:0] rdata; // read data held for the bus
      logic pin_sample; // port read of the strobe pin
   } state_t;

   // reset value of the whole state; hardware standby uses its register-file fields
   localparam state_t STATE_RESET = '{
      mode: refresh_pkg::MODE_RESET,
      compare_match_flag: 1'b0,
      cmf_seen: 1'b0,
      cmie: 1'b0,
      cks: refresh_pkg::CKS_RESET,
      count: refresh_pkg::COUNT_RESET,
      constant: refresh_pkg::CONSTANT_RESET,
      ack: 1'b0,
      rdata: 32'h00000000,
      pin_sample: 1'b0
   };

   state_t cur; // registered state
   state_t next_cur; // next state

   logic psram_bit; // pseudo_static_enable
   logic dram_bit; // dynamic_ram_enable
   logic attached; // either memory type enabled
   logic dram_only; // dram alone attached
   logic psram_only; // psram alone attached
   logic cycle_busy; // refresh cycle in progress
   logic cycle_start; // request accepted this cycle
   logic sr_active; // memory held in self-refresh
   logic sr_allowed; // self-refresh chosen for standby
   logic pin_enable; // refresh_pin_enable
   logic strobe_low; // strobe asserted
   logic bus_req; // read or write presented
   logic wr_take; // write takes effect this edge
   logic [7:0] wr_byte; // low lane of write data
   logic [7:0] rd_byte; // register selected for read

   // attachment decode; both bits set is an illegal setting
   always_comb begin
      psram_bit = cur.mode[refresh_pkg::BIT_PSRAM];
      dram_bit = cur.mode[refresh_pkg::BIT_DRAM];
      attached = psram_bit | dram_bit;
      dram_only = dram_bit & ~psram_bit;
      psram_only = psram_bit & ~dram_bit;
   end

   // self-refresh only for a legal single attachment with the select bit
   assign sr_allowed = cur.mode[refresh_pkg::BIT_SELF] & (dram_only | psram_only);

   // refresh cycles only with memory attached and the enable set
   assign cycle_start = refresh_request_in & attached & cur.mode[refresh_pkg::BIT_CYCLE]
      & ~cycle_busy & ~sr_active & ~sw_standby_in;

   // fixed three-state refresh cycle
   refresh_cycle_seq cycle_seq (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .start_in(cycle_start),
      .busy_out(cycle_busy)
   );

   // standby entry and exit of the attached memory
   self_refresh_ctl standby_ctl (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .standby_in(sw_standby_in),
      .allowed_in(sr_allowed),
      .self_refresh_out(sr_active)
   );

   // bus handshake: one wait state, then the answer
   assign bus_req = read_in | write_in;
   assign waitrequest_out = bus_req & ~cur.ack;
   assign wr_take = write_in & cur.ack & byteenable_in[0];
   assign wr_byte = writedata_in[7:0];

   // read mux from current register contents
   always_comb begin
      case (address_in)
         refresh_pkg::OFS_MODE: begin
            rd_byte = cur.mode | refresh_pkg::MODE_FIXED_ONE;
         end
         refresh_pkg::OFS_TIMER_CTRL: begin
            rd_byte = {cur.compare_match_flag, cur.cmie, cur.cks, refresh_pkg::TIMER_LOW_ONES};
         end
         refresh_pkg::OFS_COUNT: begin
            rd_byte = cur.count;
         end
         refresh_pkg::OFS_CONSTANT: begin
            rd_byte = cur.constant;
         end
         default: begin
            // unmapped words read as zero
            rd_byte = refresh_pkg::READ_UNMAPPED;
         end
      endcase
   end

   // next-state logic for the register file and bus answer
   always_comb begin
      next_cur = cur;
      next_cur.pin_sample = refresh_strobe_pin_in;
      next_cur.ack = bus_req & ~cur.ack;
      // read data is captured in the wait cycle, held through the answer
      if (read_in && !cur.ack) begin
         next_cur.rdata = {refresh_pkg::READ_UPPER, rd_byte};
         // reading the flag as one arms its clear
         if (address_in == refresh_pkg::OFS_TIMER_CTRL && cur.compare_match_flag) begin
            next_cur.cmf_seen = 1'b1;
         end
      end
      if (wr_take) begin
         case (address_in)
            refresh_pkg::OFS_MODE: begin
               // locked bits keep their value while memory is attached
               if (attached) begin
                  next_cur.mode = (cur.mode & refresh_pkg::MODE_LOCK_MASK)
                     | (wr_byte & ~refresh_pkg::MODE_LOCK_MASK);
               end else begin
                  next_cur.mode = wr_byte;
               end
               next_cur.mode = next_cur.mode | refresh_pkg::MODE_FIXED_ONE;
            end
            refresh_pkg::OFS_TIMER_CTRL: begin
               if (!attached) begin
                  next_cur.cmie = wr_byte[refresh_pkg::BIT_CMIE];
                  next_cur.cks = wr_byte[refresh_pkg::BIT_CKS_HI:refresh_pkg::BIT_CKS_LO];
               end
               // the flag clears by a zero write even when locked
               if (!wr_byte[refresh_pkg::BIT_CMF] && cur.cmf_seen) begin
                  next_cur.compare_match_flag = 1'b0;
                  next_cur.cmf_seen = 1'b0;
               end
            end
            refresh_pkg::OFS_COUNT: begin
               if (!attached) begin
                  next_cur.count = wr_byte;
               end
            end
            refresh_pkg::OFS_CONSTANT: begin
               if (!attached) begin
                  next_cur.constant = wr_byte;
               end
            end
            default: begin
               // unmapped writes are dropped
               next_cur.cmf_seen = cur.cmf_seen;
            end
         endcase
      end
      // interrupt enable forced off with memory attached
      if (attached) begin
         next_cur.cmie = 1'b0;
      end
      // a match in the clearing cycle wins over the clear
      if (compare_match_in) begin
         next_cur.compare_match_flag = 1'b1;
      end
      // hardware standby returns the registers to reset values
      if (hw_standby_in) begin
         next_cur.mode = STATE_RESET.mode;
         next_cur.compare_match_flag = STATE_RESET.compare_match_flag;
         next_cur.cmf_seen = STATE_RESET.cmf_seen;
         next_cur.cmie = STATE_RESET.cmie;
         next_cur.cks = STATE_RESET.cks;
         next_cur.count = STATE_RESET.count;
         next_cur.constant = STATE_RESET.constant;
      end
   end

   // state register
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cur <= STATE_RESET;
      end else begin
         cur <= next_cur;
      end
   end

   // strobe pin: refresh strobe when enabled, otherwise the general port
   assign pin_enable = cur.mode[refresh_pkg::BIT_PIN];
   assign strobe_low = cycle_busy | sr_active;
   always_comb begin
      if (pin_enable) begin
         refresh_strobe_pin_out = ~strobe_low;
         refresh_strobe_pin_oe_out = 1'b1;
      end else begin
         refresh_strobe_pin_out = port_data_in;
         refresh_strobe_pin_oe_out = port_oe_in;
      end
   end

   // memory-type outputs; strobe and column settings only for dram alone
   assign dram_attach_out = dram_only;
   assign psram_attach_out = psram_only;
   assign two_cas_mode_out = dram_only & cur.mode[refresh_pkg::BIT_STROBE];
   assign nine_bit_column_out = dram_only & cur.mode[refresh_pkg::BIT_COLUMN];
   // area 3 timing override; bus controller uses these over its own setting
   assign area3_three_state_out = attached;
   assign area3_wait_enable_out = attached & area3_state_select_in;
   assign refresh_cycle_out = cycle_busy;
   assign self_refresh_out = sr_active;
   // register-backed outputs
   assign readdata_out = cur.rdata;
   assign port_read_out = cur.pin_sample;
   assign compare_match_flag_out = cur.compare_match_flag;
   assign compare_interrupt_enable_out = cur.cmie;
   assign clock_select_out = cur.cks;
   assign refresh_timer_count_out = cur.count;
   assign refresh_time_constant_out = cur.constant;

   // checks on the block's own behaviour
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence s_cycle_start;
      $rose(refresh_cycle_out);
   endsequence

   sequence s_standby_sr;
      $rose(sw_standby_in) ##0 sr_allowed ##0 !self_refresh_out;
   endsequence

   a_mode_reset_value: assert property (hw_standby_in |=> cur.mode == refresh_pkg::MODE_RESET)
      else $error("mode register not back to reset value");
   a_self_refresh_entry: assert property (s_standby_sr |=> self_refresh_out)
      else $error("self-refresh not entered on standby");
   a_no_self_refresh: assert property ($rose(sw_standby_in) && !sr_allowed
      && !self_refresh_out |=> !self_refresh_out[*2])
      else $error("self-refresh entered without selection");
   a_standby_exit: assert property ($fell(sw_standby_in) |=> !self_refresh_out)
      else $error("memory not back to normal access");
   a_three_states: assert property (s_cycle_start |-> refresh_cycle_out[*3] ##1 !refresh_cycle_out)
      else $error("refresh cycle not three states");
   a_wait_gate: assert property (attached && !area3_state_select_in |-> !area3_wait_enable_out)
      else $error("wait states allowed wrongly");
   a_lock_bits: assert property (attached && wr_take && address_in == refresh_pkg::OFS_MODE && !hw_standby_in
      |=> (cur.mode & refresh_pkg::MODE_LOCK_MASK) == ($past(cur.mode) & refresh_pkg::MODE_LOCK_MASK))
      else $error("locked mode bits changed");
   a_lock_count: assert property (attached && wr_take && address_in == refresh_pkg::OFS_COUNT && !hw_standby_in
      |=> $stable(refresh_timer_count_out))
      else $error("locked count written");
   a_bit1_read: assert property (read_in && !waitrequest_out && address_in == refresh_pkg::OFS_MODE
      |-> (readdata_out[7:0] & refresh_pkg::MODE_FIXED_ONE) == refresh_pkg::MODE_FIXED_ONE)
      else $error("fixed bit read as zero");
   a_cycle_needs_attach: assert property (s_cycle_start
      |-> $past(attached && cur.mode[refresh_pkg::BIT_CYCLE]))
      else $error("refresh cycle without attachment");
   a_strobe_low: assert property (refresh_cycle_out && pin_enable
      |-> !refresh_strobe_pin_out && refresh_strobe_pin_oe_out)
      else $error("strobe not low in refresh cycle");
   a_one_wait: assert property (waitrequest_out |=> !waitrequest_out || !bus_req)
      else $error("bus answer late");
   a_flag_set_wins: assert property (compare_match_in && !hw_standby_in |=> compare_match_flag_out)
      else $error("compare flag lost");
endmodule : refresh_mode_control

// file: bench/mem_partner.sv
// area 3 memory model: watches the refresh strobe wire
// assumes a pull-up on the wire while the device releases it
`timescale 1ns/1ps
module mem_partner (
   input wire logic clk_in,
   input wire logic clear_in,
   input wire logic drive_in,
   input wire logic oe_in,
   output logic level_out,
   output logic [7:0] low_cycles_out
);
   // released wire floats high, never holds the old value
   assign level_out = oe_in ? drive_in : 1'b1;
   // count states with the strobe low, as the memory sees them
   always_ff @(posedge clk_in) begin
      if (clear_in) begin
         low_cycles_out <= 8'h00;
      end else if (!level_out) begin
         low_cycles_out <= low_cycles_out + 8'h01;
      end
   end
endmodule : mem_partner

// file: bench/refresh_mode_control_tb_top.sv
// bench for the refresh mode-control block over avalon-mm
// assumes the memory model owns the strobe wire pull-up
`timescale 1ns/1ps
`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module refresh_mode_control_tb_top;
   localparam logic [3:0] MR = refresh_pkg::OFS_MODE;
   localparam logic [3:0] TC = refresh_pkg::OFS_TIMER_CTRL;
   localparam logic [3:0] CN = refresh_pkg::OFS_COUNT;
   localparam logic [3:0] CO = refresh_pkg::OFS_CONSTANT;
   logic clk, rst, hw, sw, rd_s, wr_s, cm, rq, ast, pdata, poe, clr;
   logic [3:0] addr, be;
   logic [31:0] wdata, rdata;
   logic wreq, pin_out, pin_oe, pin_lvl, port_rd, dram, psram, two_cas, nine;
   logic three_st, wait_en, ref_cyc, self_ref, cmf_o, cmie_o;
   logic [2:0] cks_o;
   logic [7:0] lows, q, cnt_o, con_o;
   int failures, n_compared, hi;
   // self-refresh cases: mode value and expected outcome
   logic [7:0] sr_mode [3] = '{8'hc5, 8'ha5, 8'h45};
   logic sr_exp [3] = '{1'b1, 1'b1, 1'b0};
   refresh_mode_control dut (.clk_in(clk), .rst_in(rst), .hw_standby_in(hw), .sw_standby_in(sw),
      .address_in(addr), .read_in(rd_s), .write_in(wr_s), .writedata_in(wdata), .byteenable_in(be),
      .readdata_out(rdata), .waitrequest_out(wreq), .compare_match_in(cm), .refresh_request_in(rq),
      .area3_state_select_in(ast), .refresh_strobe_pin_in(pin_lvl), .port_data_in(pdata),
      .port_oe_in(poe), .refresh_strobe_pin_out(pin_out), .refresh_strobe_pin_oe_out(pin_oe),
      .port_read_out(port_rd), .dram_attach_out(dram), .psram_attach_out(psram),
      .two_cas_mode_out(two_cas), .nine_bit_column_out(nine), .area3_three_state_out(three_st),
      .area3_wait_enable_out(wait_en), .refresh_cycle_out(ref_cyc), .self_refresh_out(self_ref),
      .compare_match_flag_out(cmf_o), .compare_interrupt_enable_out(cmie_o), .clock_select_out(cks_o),
      .refresh_timer_count_out(cnt_o), .refresh_time_constant_out(con_o));
   // far side: strobe wire and refresh counting
   mem_partner mem (.clk_in(clk), .clear_in(clr), .drive_in(pin_out), .oe_in(pin_oe),
      .level_out(pin_lvl), .low_cycles_out(lows));
   // verdict and end of run
   task automatic conclude;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude
   // wait a number of edges
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // one avalon access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      n = 0;
      addr <= a;
      wdata <= {24'h000000, d};
      wr_s <= w;
      rd_s <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 16);
      q = rdata[7:0];
      // a slave that never answers ends the run
      if (n >= 16) begin
         failures++;
         conclude();
      end
      wr_s <= 1'b0;
      rd_s <= 1'b0;
      // one idle edge so the next request is a fresh rise
      @(posedge clk);
   endtask : bus
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr
   // read and compare one register
   task automatic chk(input logic [3:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      `CHECK(q, e)
   endtask : chk
   // clock, 5 ns period
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      conclude();
   end
   initial begin
      rst = 1'b1; hw = 1'b0; sw = 1'b0; rd_s = 1'b0; wr_s = 1'b0; addr = 4'h0; wdata = 32'h0;
      be = 4'h1; cm = 1'b0; rq = 1'b0; ast = 1'b0; pdata = 1'b1; poe = 1'b0; clr = 1'b1;
      failures = 0;
      n_compared = 0;
      tick(8);
      rst <= 1'b0;
      clr <= 1'b0;
      tick(1);
      // reset values, then an unmapped offset
      chk(MR, 8'h02);
      chk(TC, 8'h07);
      chk(CN, 8'h00);
      chk(CO, 8'hff);
      chk(4'h2, 8'h00);
      // bit 1 cannot be cleared
      wr(MR, 8'h00);
      chk(MR, 8'h02);
      // strobe and column bits do nothing without dram
      wr(MR, 8'h1d);
      chk(MR, 8'h1f);
      `CHECK(two_cas, 1'b0)
      `CHECK(nine, 1'b0)
      `CHECK(three_st, 1'b0)
      // refresh request while unattached is dropped
      ast <= 1'b1;
      rq <= 1'b1;
      hi = 0;
      repeat (8) begin
         @(posedge clk);
         rq <= 1'b0;
         if (ref_cyc !== 1'b0) hi++;
      end
      `CHECK(hi, 0)
      `CHECK(wait_en, 1'b0)
      // dram alone attached
      wr(MR, 8'h3d);
      `CHECK(dram, 1'b1)
      `CHECK(psram, 1'b0)
      `CHECK(two_cas, 1'b1)
      `CHECK(nine, 1'b1)
      `CHECK(three_st, 1'b1)
      `CHECK(wait_en, 1'b1)
      ast <= 1'b0;
      tick(1);
      `CHECK(wait_en, 1'b0)
      // locked bits and timer registers ignore writes
      wr(MR, 8'h20);
      chk(MR, 8'h3f);
      wr(CN, 8'h55);
      chk(CN, 8'h00);
      wr(CO, 8'h12);
      chk(CO, 8'hff);
      wr(TC, 8'h38);
      chk(TC, 8'h07);
      // flag may still be cleared by read then zero write
      cm <= 1'b1;
      tick(1);
      cm <= 1'b0;
      tick(1);
      `CHECK(cmf_o, 1'b1)
      chk(TC, 8'h87);
      wr(TC, 8'h00);
      chk(TC, 8'h07);
      // a match in the clearing cycle keeps the flag set
      cm <= 1'b1;
      tick(1);
      chk(TC, 8'h87);
      wr(TC, 8'h00);
      cm <= 1'b0;
      chk(TC, 8'h87);
      wr(TC, 8'h00);
      chk(TC, 8'h07);
      `CHECK(cmf_o, 1'b0)
      // request held two edges: the second falls in the busy cycle
      clr <= 1'b1;
      tick(1);
      clr <= 1'b0;
      rq <= 1'b1;
      tick(1);
      hi = 0;
      // count from the first busy edge, dropping the request after it
      repeat (10) begin
         @(posedge clk);
         rq <= 1'b0;
         if (ref_cyc !== 1'b0) hi++;
      end
      `CHECK(hi, 3)
      `CHECK(lows, 8'h03)
      `CHECK(pin_oe, 1'b1)
      // detaching keeps the locked bits once, then clears them
      wr(MR, 8'h00);
      chk(MR, 8'h1f);
      wr(MR, 8'h00);
      chk(MR, 8'h02);
      // pin released to the general port
      poe <= 1'b1;
      pdata <= 1'b0;
      tick(2);
      `CHECK(pin_out, 1'b0)
      `CHECK(port_rd, 1'b0)
      poe <= 1'b0;
      tick(2);
      `CHECK(pin_oe, 1'b0)
      `CHECK(port_rd, 1'b1)
      // software standby per attachment and select bit
      for (int i = 0; i < 3; i++) begin
         wr(MR, 8'h05);
         wr(MR, sr_mode[i]);
         sw <= 1'b1;
         tick(3);
         `CHECK(self_ref, sr_exp[i])
         `CHECK(pin_lvl, ~sr_exp[i])
         sw <= 1'b0;
         tick(3);
         `CHECK(self_ref, 1'b0)
         wr(MR, 8'h00);
      end
      // illegal both-bits setting: no memory type, area 3 still three states
      wr(MR, 8'h60);
      `CHECK(dram, 1'b0)
      `CHECK(psram, 1'b0)
      `CHECK(three_st, 1'b1)
      wr(MR, 8'h00);
      // unlocked timer writes reach the outputs
      wr(TC, 8'h58);
      wr(CN, 8'h55);
      wr(CO, 8'h12);
      `CHECK(cmie_o, 1'b1)
      `CHECK(cks_o, 3'h3)
      `CHECK(cnt_o, 8'h55)
      `CHECK(con_o, 8'h12)
      // attaching forces the interrupt enable off and locks the counter
      wr(MR, 8'h20);
      wr(CN, 8'haa);
      `CHECK(cmie_o, 1'b0)
      `CHECK(cnt_o, 8'h55)
      // hardware standby returns the mode register to reset
      hw <= 1'b1;
      tick(1);
      hw <= 1'b0;
      tick(1);
      chk(MR, 8'h02);
      `CHECK(dram, 1'b0)
      `CHECK(cnt_o, 8'h00)
      `CHECK(cks_o, 3'h0)
      conclude();
   end
endmodule : refresh_mode_control_tb_top
